// [port_output_shutdown_control.sv]
// Output shutdown unit: fault inputs, short checks and pin disable logic.
`timescale 1ns/1ps
`default_nettype none
module port_output_shutdown_control (
    input  wire  logic                                ref_clk_i,
    input  wire  logic                                nrst_i,
    input  wire  poe_pkg::bus_req_s                   bus_i,
    output logic [poe_pkg::DATA_W-1:0]                rdata_o,
    input  wire  logic [poe_pkg::NUM_IN-1:0]          shutdown_in_n_i,
    input  wire  logic [poe_pkg::NUM_MT-1:0]          mt_pair_a_i,
    input  wire  logic [poe_pkg::NUM_MT-1:0]          mt_pair_b_i,
    input  wire  logic [poe_pkg::NUM_PWM-1:0]         pwm_pair_a_i,
    input  wire  logic [poe_pkg::NUM_PWM-1:0]         pwm_pair_b_i,
    input  wire  logic                                osc_stop_i,
    input  wire  logic                                cmp_detect_i,
    output logic [poe_pkg::NUM_MT_PINS-1:0]           mt_disable_o,
    output logic [poe_pkg::NUM_PWM_PINS-1:0]          pwm_disable_o,
    output logic                                      port_mode_o,
    output logic                                      in_irq_o,
    output logic                                      cmp_irq_o
);
    import poe_pkg::*;

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Byte offset of the control register of input k.
    function automatic logic [ADDR_W-1:0] in_addr(input int k);
        in_addr = ADDR_W'(IN_CTRL_BASE + k * IN_CTRL_STRIDE);
    endfunction

    // Sampling strobe for a level mode from the shared prescaler.
    function automatic logic sample_tick(input logic [3:0] mode,
                                         input logic [PRESC_W-1:0] p);
        case (mode)
            MODE_DIV1:   sample_tick = 1'b1;
            MODE_DIV2:   sample_tick = p[0];
            MODE_DIV4:   sample_tick = &p[1:0];
            MODE_DIV8:   sample_tick = &p[2:0];
            MODE_DIV16:  sample_tick = &p[3:0];
            MODE_DIV128: sample_tick = &p;
            default:     sample_tick = 1'b0;
        endcase
    endfunction

    // Number of consecutive low samples a count code asks for.
    function automatic logic [SCNT_W-1:0] samples_needed(
        input logic [3:0] code);
        case (code)
            CNT_8:   samples_needed = SAMPLES_8;
            CNT_4:   samples_needed = SAMPLES_4;
            default: samples_needed = SAMPLES_16;
        endcase
    endfunction

    // Maps data bits of the addressed register onto the flag vector.
    function automatic logic [NF-1:0] flag_of(input logic [ADDR_W-1:0] a,
                                              input logic [DATA_W-1:0] d);
        logic [NF-1:0] m;
        m = '0;
        for (int k = 0; k < NUM_IN; k++) begin
            if (a == in_addr(k)) begin
                m[FI_IN + k] = d[IN_FLAG_BIT];
            end
        end
        if (a == CMP_FLAG_OFS) begin
            m[FI_MT +: NUM_MT]   = d[CMP_MT_LSB +: NUM_MT];
            m[FI_PWM +: NUM_PWM] = d[CMP_PWM_LSB +: NUM_PWM];
        end
        if (a == MISC_OFS) begin
            m[FI_OSC]  = d[OSC_FLAG_BIT];
            m[FI_COMP] = d[COMP_FLAG_BIT];
        end
        flag_of = m;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic [3:0]          in_mode   [NUM_IN];
    logic [3:0]          in_cnt    [NUM_IN];
    logic [NUM_IN-1:0]   in_irq_en;
    logic [NUM_IN-1:0]   in_od_en;
    logic [NUM_MT-1:0]   mt_en;
    logic [NUM_PWM-1:0]  pwm_en;
    logic                cmp_irq_en;
    logic                osc_en;
    logic                comp_en;
    logic                soft_dis;
    logic                port_mode;
    logic [NF-1:0]       flags;
    logic [NF-1:0]       armed;
    logic [NUM_IN-1:0]   pin_meta;
    logic [NUM_IN-1:0]   pin_sync;
    logic [NUM_IN-1:0]   pin_prev;
    logic [1:0]          misc_meta;
    logic [1:0]          misc_sync;
    logic [PRESC_W-1:0]  presc;
    logic [SCNT_W-1:0]   low_cnt   [NUM_IN];
    logic [SCNT_W-1:0]   need      [NUM_IN];
    logic [NUM_IN-1:0]   det;
    logic [NF-1:0]       set_vec;
    logic [NF-1:0]       clr_vec;
    logic [NF-1:0]       acc_mask;
    logic [DATA_W-1:0]   rd_value;
    logic                dis_any;

    // ************************************************************
    // Input synchronisers
    // ************************************************************

    // Pins and the two foreign levels pass two flops before any use.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_meta  <= '1;
            pin_sync  <= '1;
            pin_prev  <= '1;
            misc_meta <= 2'h0;
            misc_sync <= 2'h0;
        end else begin
            pin_meta  <= shutdown_in_n_i;
            pin_sync  <= pin_meta;
            pin_prev  <= pin_sync;
            misc_meta <= {cmp_detect_i, osc_stop_i};
            misc_sync <= misc_meta;
        end
    end

    // One free running prescaler serves every divide ratio.
    // shared sampling divider
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            presc <= PRESC_RST;
        end else begin
            presc <= presc + 7'h01;
        end
    end

    // ************************************************************
    // Per input detection
    // ************************************************************
    generate
        for (genvar i = 0; i < NUM_IN; i++) begin : g_in
            logic tick;
            assign tick = sample_tick(in_mode[i], presc);
            assign need[i] = samples_needed(in_cnt[i]);

            // The run counter saturates so a held low trips only once.
            // consecutive low run
            always_ff @(posedge ref_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    low_cnt[i] <= 5'h00;
                end else if (in_mode[i] == MODE_EDGE) begin
                    low_cnt[i] <= 5'h00;
                end else if (tick) begin
                    if (pin_sync[i]) begin
                        low_cnt[i] <= 5'h00;
                    end else if (low_cnt[i] != need[i]) begin
                        low_cnt[i] <= low_cnt[i] + 5'h01;
                    end
                end
            end

            // Edge or level event per the input's mode.
            // per input choice
            always_comb begin
                if (in_mode[i] == MODE_EDGE) begin
                    det[i] = pin_prev[i] & ~pin_sync[i];
                end else begin
                    det[i] = tick & ~pin_sync[i]
                             & (low_cnt[i] == need[i] - 5'h01);
                end
            end
        end
    endgenerate

    // ************************************************************
    // Flag set and clear
    // ************************************************************

    // Set sources; the short checks look at one cycle of overlap.
    // input flag set
    always_comb begin
        set_vec = '0;
        set_vec[FI_IN +: NUM_IN]    = det;
        set_vec[FI_MT +: NUM_MT]    = mt_en & mt_pair_a_i & mt_pair_b_i;
        set_vec[FI_PWM +: NUM_PWM]  = pwm_en & pwm_pair_a_i & pwm_pair_b_i;
        set_vec[FI_OSC]             = osc_en & misc_sync[0];
        set_vec[FI_COMP]            = comp_en & misc_sync[1];
    end

    // A zero written to an armed flag clears it; level inputs also
    // need the pin back high, else a live fault would be hidden.
    // read then zero
    always_comb begin
        acc_mask = flag_of(bus_i.addr, 16'hffff);
        clr_vec  = '0;
        if (bus_i.wr) begin
            clr_vec = acc_mask & ~flag_of(bus_i.addr, bus_i.wdata) & armed;
        end
        for (int k = 0; k < NUM_IN; k++) begin
            if (in_mode[k] != MODE_EDGE && !pin_sync[k]) begin
                clr_vec[FI_IN + k] = 1'b0;
            end
        end
    end

    // Set wins over a clear in the same cycle.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clr_vec) | set_vec;
        end
    end

    // A read of one arms a flag; a write to its register disarms it unless a read comes in the same cycle.
    // arm on read
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            armed <= '0;
        end else if (bus_i.rd) begin
            armed <= armed | (acc_mask & flags);
        end else if (bus_i.wr) begin
            armed <= armed & ~acc_mask;
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************

    // Input control fields.
    // mode and count
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int k = 0; k < NUM_IN; k++) begin
                in_mode[k] <= MODE_RST;
                in_cnt[k]  <= CNT_RST;
            end
            in_irq_en <= '0;
            in_od_en  <= '0;
        end else if (bus_i.wr) begin
            for (int k = 0; k < NUM_IN; k++) begin
                if (bus_i.addr == in_addr(k)) begin
                    in_mode[k]   <= bus_i.wdata[MODE_LSB +: 4];
                    in_cnt[k]    <= bus_i.wdata[CNT_LSB +: 4];
                    in_irq_en[k] <= bus_i.wdata[IRQ_EN_BIT];
                    in_od_en[k]  <= bus_i.wdata[OD_EN_BIT];
                end
            end
        end
    end

    // Short check enables, misc enables and the software disable.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mt_en      <= '0;
            pwm_en     <= '0;
            cmp_irq_en <= EN_RST;
            osc_en     <= EN_RST;
            comp_en    <= EN_RST;
            soft_dis   <= EN_RST;
            port_mode  <= EN_RST;
        end else if (bus_i.wr) begin
            if (bus_i.addr == CMP_CTRL_OFS) begin
                mt_en      <= bus_i.wdata[CMP_MT_LSB +: NUM_MT];
                pwm_en     <= bus_i.wdata[CMP_PWM_LSB +: NUM_PWM];
                cmp_irq_en <= bus_i.wdata[CMP_IRQ_BIT];
            end
            if (bus_i.addr == MISC_OFS) begin
                osc_en  <= bus_i.wdata[OSC_EN_BIT];
                comp_en <= bus_i.wdata[COMP_EN_BIT];
            end
            if (bus_i.addr == SOFT_OFS) begin
                soft_dis  <= bus_i.wdata[SOFT_DIS_BIT];
                port_mode <= bus_i.wdata[PORT_MODE_BIT];
            end
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************

    // Unmapped offsets read zero.
    always_comb begin
        rd_value = '0;
        for (int k = 0; k < NUM_IN; k++) begin
            if (bus_i.addr == in_addr(k)) begin
                rd_value[MODE_LSB +: 4] = in_mode[k];
                rd_value[CNT_LSB +: 4]  = in_cnt[k];
                rd_value[IRQ_EN_BIT]    = in_irq_en[k];
                rd_value[OD_EN_BIT]     = in_od_en[k];
                rd_value[IN_FLAG_BIT]   = flags[FI_IN + k];
            end
        end
        case (bus_i.addr)
            CMP_CTRL_OFS: begin
                rd_value[CMP_MT_LSB +: NUM_MT]   = mt_en;
                rd_value[CMP_PWM_LSB +: NUM_PWM] = pwm_en;
                rd_value[CMP_IRQ_BIT]            = cmp_irq_en;
            end
            CMP_FLAG_OFS: begin
                rd_value[CMP_MT_LSB +: NUM_MT]   = flags[FI_MT +: NUM_MT];
                rd_value[CMP_PWM_LSB +: NUM_PWM] = flags[FI_PWM +: NUM_PWM];
            end
            MISC_OFS: begin
                rd_value[OSC_EN_BIT]    = osc_en;
                rd_value[OSC_FLAG_BIT]  = flags[FI_OSC];
                rd_value[COMP_EN_BIT]   = comp_en;
                rd_value[COMP_FLAG_BIT] = flags[FI_COMP];
            end
            SOFT_OFS: begin
                rd_value[SOFT_DIS_BIT]  = soft_dis;
                rd_value[PORT_MODE_BIT] = port_mode;
            end
            default: begin
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= bus_i.rd ? rd_value : '0;
        end
    end

    // ************************************************************
    // Output disable and requests
    // ************************************************************

    // Any live flag holds the disable (an input flag only with its in_od_en set),
    // so clearing one source while another is still set keeps the bridge safe.
    // input source gate
    assign dis_any = |(flags[FI_IN +: NUM_IN] & in_od_en)
                   | |flags[FI_MT +: NUM_MT]
                   | |flags[FI_PWM +: NUM_PWM]
                   | flags[FI_OSC] | flags[FI_COMP] | soft_dis;

    // Every target pin shares one group.
    // all target pins
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mt_disable_o  <= '0;
            pwm_disable_o <= '0;
            port_mode_o   <= 1'b0;
        end else begin
            mt_disable_o  <= {NUM_MT_PINS{dis_any}};
            pwm_disable_o <= {NUM_PWM_PINS{dis_any}};
            port_mode_o   <= port_mode;
        end
    end

    // Level interrupt requests for the system interrupt controller.
    // detection requests
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            in_irq_o  <= 1'b0;
            cmp_irq_o <= 1'b0;
        end else begin
            in_irq_o  <= |(flags[FI_IN +: NUM_IN] & in_irq_en);
            cmp_irq_o <= cmp_irq_en & (|flags[FI_MT +: NUM_MT]
                                       | |flags[FI_PWM +: NUM_PWM]);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    a_edge_sets_flag: assert property (
        in_mode[0] == MODE_EDGE && pin_prev[0] && !pin_sync[0]
        |=> flags[FI_IN])
        else $error("edge did not set input flag");
    a_level_run_len: assert property (
        $rose(flags[FI_IN]) && $past(in_mode[0]) != MODE_EDGE
        |-> $past(low_cnt[0]) == $past(need[0]) - 5'h01)
        else $error("level flag set before full low run");
    a_clear_needs_arm: assert property (
        $fell(flags[FI_IN]) |-> $past(armed[FI_IN]) && $past(bus_i.wr))
        else $error("flag cleared without read of one");
    a_level_clear_high: assert property (
        $fell(flags[FI_IN]) && $past(in_mode[0]) != MODE_EDGE
        |-> $past(pin_sync[0]))
        else $error("level flag cleared while pin low");
    a_input_disables: assert property (
        flags[FI_IN] && in_od_en[0]
        |=> &mt_disable_o && &pwm_disable_o)
        else $error("input flag did not disable pins");
    a_osc_disables: assert property (
        osc_en && misc_sync[0] |-> ##2 &pwm_disable_o)
        else $error("oscillator stop did not disable");
    a_mt_short: assert property (
        mt_en[0] && mt_pair_a_i[0] && mt_pair_b_i[0]
        |=> flags[FI_MT] ##1 &mt_disable_o)
        else $error("multi-timer overlap missed");
    a_pwm_short: assert property (
        pwm_en[0] && pwm_pair_a_i[0] && pwm_pair_b_i[0]
        |=> flags[FI_PWM] ##1 &pwm_disable_o)
        else $error("pwm overlap missed");
    a_comp_disables: assert property (
        comp_en && misc_sync[1] |-> ##2 &mt_disable_o)
        else $error("comparator detection did not disable");
    a_soft_disable: assert property (
        soft_dis |=> &mt_disable_o && &pwm_disable_o)
        else $error("software disable ignored");
    a_input_irq: assert property (
        flags[FI_IN] && in_irq_en[0] |=> in_irq_o)
        else $error("input interrupt request missing");
    a_hold_release: assert property (
        $fell(mt_disable_o[0])
        |-> !$past(soft_dis) && $past(flags[FI_MT +: NUM_MT]) == '0
            && $past(flags[FI_PWM +: NUM_PWM]) == '0)
        else $error("outputs released with source active");

    c_edge_trip:  cover property (in_mode[0] == MODE_EDGE ##1 $rose(flags[0]));
    c_level_trip: cover property (in_mode[0] == MODE_DIV1 ##1 $rose(flags[0]));
    c_short_trip: cover property ($rose(flags[FI_PWM]));
    c_flag_clear: cover property ($fell(flags[FI_IN]));

endmodule // port_output_shutdown_control
`default_nettype wire

// [poe_pkg.sv]
// Constants, register map and bus carrier for the output shutdown unit.
`default_nettype none
package poe_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 16;
    localparam int NUM_IN       = 9;
    localparam int NUM_MT       = 6;
    localparam int NUM_PWM      = 9;
    localparam int NUM_MT_PINS  = 20;
    localparam int NUM_PWM_PINS = 20;
    localparam int PRESC_W      = 7;
    localparam int SCNT_W       = 5;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] IN_CTRL_BASE   = 8'h00;
    localparam logic [7:0] IN_CTRL_STRIDE = 8'h02;
    localparam logic [7:0] CMP_CTRL_OFS   = 8'h12;
    localparam logic [7:0] CMP_FLAG_OFS   = 8'h14;
    localparam logic [7:0] MISC_OFS       = 8'h16;
    localparam logic [7:0] SOFT_OFS       = 8'h18;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int MODE_LSB    = 0;
    localparam int CNT_LSB     = 4;
    localparam int IRQ_EN_BIT  = 8;
    localparam int OD_EN_BIT   = 9;
    localparam int IN_FLAG_BIT = 12;
    localparam int CMP_MT_LSB  = 0;
    localparam int CMP_PWM_LSB = 6;
    localparam int CMP_IRQ_BIT = 15;
    localparam int OSC_EN_BIT  = 0;
    localparam int OSC_FLAG_BIT = 1;
    localparam int COMP_EN_BIT = 2;
    localparam int COMP_FLAG_BIT = 3;
    localparam int SOFT_DIS_BIT = 0;
    localparam int PORT_MODE_BIT = 1;

    // Positions inside the flat flag vector.
    localparam int FI_IN   = 0;
    localparam int FI_MT   = 9;
    localparam int FI_PWM  = 15;
    localparam int FI_OSC  = 24;
    localparam int FI_COMP = 25;
    localparam int NF      = 26;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [3:0] MODE_RST  = 4'h0;
    localparam logic [3:0] CNT_RST   = 4'h0;
    localparam logic       EN_RST    = 1'b0;
    localparam logic [PRESC_W-1:0] PRESC_RST = 7'h00;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [3:0] MODE_EDGE   = 4'h0;
    localparam logic [3:0] MODE_DIV8   = 4'h1;
    localparam logic [3:0] MODE_DIV16  = 4'h2;
    localparam logic [3:0] MODE_DIV128 = 4'h3;
    localparam logic [3:0] MODE_DIV1   = 4'h4;
    localparam logic [3:0] MODE_DIV2   = 4'h5;
    localparam logic [3:0] MODE_DIV4   = 4'h6;
    localparam logic [3:0] CNT_16      = 4'h0;
    localparam logic [3:0] CNT_8       = 4'h1;
    localparam logic [3:0] CNT_4       = 4'h2;
    localparam logic [SCNT_W-1:0] SAMPLES_16 = 5'h10;
    localparam logic [SCNT_W-1:0] SAMPLES_8  = 5'h08;
    localparam logic [SCNT_W-1:0] SAMPLES_4  = 5'h04;

    // Register port request carrier.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_s;

endpackage
`default_nettype wire

// [pair_model.sv]
// Model of complementary timer legs feeding the pair comparators.
`timescale 1ns/1ps
`default_nettype none
module pair_model (
    input  wire logic       ref_clk_i,
    input  wire logic       short_i,
    output logic [5:0]      a_o,
    output logic [5:0]      b_o
);
    logic ph = 1'b0;
    // Legs alternate so a healthy bridge never overlaps.
    always_ff @(posedge ref_clk_i) ph <= ~ph;
    assign a_o = {6{ph | short_i}};
    assign b_o = {6{~ph | short_i}};
endmodule // pair_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the output shutdown unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import poe_pkg::*;
    logic clk = 0, nrst = 0, pin0 = 1, sh = 0, osc = 0, cmp = 0, rd_d = 0;
    logic [7:0] rpin = '1;
    logic [8:0] pa = '0, pb = '0;
    logic [5:0] ma, mb;
    logic [19:0] md, pd;
    logic [15:0] rdata, e;
    logic pm, iq, cq, psh = 0;
    logic [31:0] rng = 32'd11;
    bus_req_s bus = '0;
    logic [15:0] exp_q[$];
    int error_cnt = 0, n_compared = 0, cyc = 0;
    port_output_shutdown_control i_dut (.ref_clk_i(clk), .nrst_i(nrst),
        .bus_i(bus), .rdata_o(rdata), .shutdown_in_n_i({rpin, pin0}),
        .mt_pair_a_i(ma), .mt_pair_b_i(mb), .pwm_pair_a_i(pa),
        .pwm_pair_b_i(pb), .osc_stop_i(osc), .cmp_detect_i(cmp),
        .mt_disable_o(md), .pwm_disable_o(pd), .port_mode_o(pm),
        .in_irq_o(iq), .cmp_irq_o(cq));
    pair_model i_pair (.ref_clk_i(clk), .short_i(sh), .a_o(ma), .b_o(mb));
    initial forever #2.5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13; s ^= s >> 17; s ^= s << 5;
        return s;
    endfunction
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin error_cnt++; $display("BAD %0t %s", $time, m); end
    endtask
    task automatic idle(input int n);
        bus <= '0;
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(x);
        @(posedge clk);
    endtask
    // Unused fault pins and PWM legs get noise; their enables stay off, except pwm_en[0] during the PWM short test.
    // Read data are checked against the oldest note; a hang is cut here.
    always @(posedge clk) begin
        rng <= xs(rng);
        rpin <= rng[7:0];
        pa <= rng[16:8] | {9{psh}};
        pb <= rng[25:17] | {9{psh}};
        cyc <= cyc + 1;
        if (rd_d) begin
            n_compared++;
            e = exp_q.pop_front();
            if (rdata !== e) begin error_cnt++; $display("BAD %0t read %h", $time, rdata); end
        end
        rd_d <= bus.rd;
        if (cyc == 5000) begin error_cnt++; conclude(); end
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(IN_CTRL_BASE, 16'h0000);
        wr(IN_CTRL_BASE, 16'h0200);
        pin0 <= 1'b0;
        idle(6);
        chk(&md && &pd, "edge no disable");
        pin0 <= 1'b1;
        wr(IN_CTRL_BASE, 16'h0200); idle(3);
        chk(&md, "blind clear");
        rd(IN_CTRL_BASE, 16'h1200); idle(1); wr(IN_CTRL_BASE, 16'h0200); idle(3);
        chk(md === '0, "no release");
        $display("edge test done");
        wr(IN_CTRL_BASE, 16'h0324);
        pin0 <= 1'b0; idle(3); pin0 <= 1'b1; idle(6);
        rd(IN_CTRL_BASE, 16'h0324);
        pin0 <= 1'b0; idle(10);
        chk(iq === 1'b1 && &md, "level");
        rd(IN_CTRL_BASE, 16'h1324); idle(1); wr(IN_CTRL_BASE, 16'h0324); idle(2);
        rd(IN_CTRL_BASE, 16'h1324);
        pin0 <= 1'b1; idle(4);
        rd(IN_CTRL_BASE, 16'h1324); idle(1); wr(IN_CTRL_BASE, 16'h0324); idle(3);
        chk(md === '0 && iq === 1'b0, "level clear");
        $display("level test done");
        wr(CMP_CTRL_OFS, 16'h8001);
        sh <= 1'b1; idle(4); sh <= 1'b0;
        chk(cq === 1'b1 && &pd, "short");
        rd(CMP_FLAG_OFS, 16'h0001); idle(1); wr(CMP_FLAG_OFS, 16'h0); idle(3);
        chk(md === '0, "short clear");
        wr(SOFT_OFS, 16'h0003); idle(3);
        chk(&md && pm === 1'b1, "soft");
        wr(SOFT_OFS, 16'h0); idle(3);
        chk(md === '0 && pm === 1'b0, "soft off");
        for (int i = 0; i < 2; i++) begin
            wr(MISC_OFS, 16'h1 << 2 * i);
            {cmp, osc} <= 2'b01 << i; idle(6);
            chk(&md, "osc or cmp");
            {cmp, osc} <= 2'b00;
            rd(MISC_OFS, 16'h3 << 2 * i); idle(1); wr(MISC_OFS, 16'h0); idle(3);
            chk(md === '0, "osc or cmp clear");
        end
        wr(CMP_CTRL_OFS, 16'h0040);
        psh <= 1'b1; idle(5); psh <= 1'b0;
        chk(&pd && &md, "pwm short");
        wr(CMP_CTRL_OFS, 16'h0);
        rd(CMP_FLAG_OFS, 16'h0040); idle(1); wr(CMP_FLAG_OFS, 16'h0); idle(3);
        chk(pd === '0, "pwm clear");
        $display("source test done");
        // Every level code, each with one count code (each count code twice); the run must not trip
        // one sample early and must trip within one more sample period.
        for (int m = 1; m < 7; m++) begin
            int c, n, d;
            c = (m + 2) % 3;
            n = 16 >> c;
            d = (m > 3) ? 1 << (m - 4) : (m == 3) ? 128 : 4 << m;
            wr(IN_CTRL_BASE, {8'h03, c[3:0], m[3:0]});
            pin0 <= 1'b0; idle(4 + (n - 1) * d);
            chk(md === '0, "level too early");
            idle(d + 2);
            chk(&md && iq === 1'b1, "level late");
            pin0 <= 1'b1; idle(3);
            rd(IN_CTRL_BASE, {8'h13, c[3:0], m[3:0]});
            wr(IN_CTRL_BASE, 16'h0); idle(3);
            chk(md === '0, "level rearm");
        end
        $display("mode test done");
        conclude();
    end
endmodule // tb_top
`default_nettype wire
